// ---- crf_defines.svh ----
/*
 * constants of the capture record formatter: type codes, header sizes,
 * extension more bit position and hash width.
 * assumes inclusion by the formatter package and module only.
 */
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// ----------------------------------------
// record type codes
// ----------------------------------------
`define CRF_TYPE_HDLC                     7'h01
`define CRF_ETHERNET_RECORD_TYPE          7'h02
`define CRF_TYPE_COLOR_HDLC               7'h0a
`define CRF_COLORED_ETHERNET_RECORD_TYPE  7'h0b
`define CRF_TYPE_HASH_HDLC                7'h13
`define CRF_HASHED_ETHERNET_RECORD_TYPE   7'h14
`define CRF_TYPE_RAW_LINK                 7'h18
`define CRF_TYPE_PAD                      7'h30
`define CRF_TYPE_RSV_LO                   7'h20
`define CRF_TYPE_RSV_HI                   7'h2f

// ----------------------------------------
// sizes in bytes, extension more bit position and hash width in bits
// ----------------------------------------
`define CRF_GEN_HDR_BYTES    16'h0010
`define CRF_EXT_HDR_BYTES    16'h0008
`define CRF_HDLC_PFX_BYTES   16'h0004
`define CRF_ETH_PFX_BYTES    16'h0002
`define CRF_EXT_MORE_BIT     7
`define CRF_HASH_BITS        4

`endif

// ---- crf_pkg.sv ----
/*
 * types of the capture record formatter.
 * assumes crf_defines.svh on the include path.
 */
`include "crf_defines.svh"
package crf_pkg;

	typedef enum logic [2:0] {
		CRF_HDLC       = 3'h0,
		CRF_ETH        = 3'h1,
		CRF_COLOR_HDLC = 3'h2,
		CRF_COLOR_ETH  = 3'h3,
		CRF_HASH_HDLC  = 3'h4,
		CRF_HASH_ETH   = 3'h5
	} crf_variant_type;

	// descriptor of one captured frame, handed over at frame start
	typedef struct packed {
		crf_variant_type variant;
		logic [63:0]     timestamp;
		logic [7:0]      flags;
		logic [15:0]     wire_len;
		logic [15:0]     loss_count;
		logic [1:0]      stream_hit;
		logic [13:0]     filter_rule;
		logic [3:0]      hash;
		logic [31:0]     link_header;
		logic [2:0]      ext_count;
		logic [15:0]     payload_len;
	} crf_desc_type;

endpackage

// ---- crf_formatter.sv ----
/*
 * capture record formatter: turns a frame descriptor, its extension header
 * words and its payload bytes into one record byte stream.
 * assumes the descriptor is held stable while in_ready is high after a start,
 * that extension and payload sources hold their data until taken, and that
 * the host memory path accepts bytes with out_ready back-pressure.
 */
`timescale 1ns/1ps
`include "crf_defines.svh"

// Contract
// - type byte msb set when extension headers follow; low seven bits hold code.
// - every extension header emitted is exactly eight bytes.
// - extension type byte msb is one except on the last header.
// - extension low seven bits pass through unchanged from the source.
// - codes 24 and 48 are raw and pad; 32 to 47 never emitted.
// - HDLC uses code 1, four-byte link header after generic header.
// - HDLC payload equals length minus 16, extensions, minus four.
// - Ethernet uses code 2, offset byte then pad byte before frame.
// - frame starts right after the pad byte.
// - Ethernet payload equals length minus 16, extensions, minus two.
// - colored HDLC code 10, color tag replaces loss counter.
// - colored Ethernet code 11, color tag replaces loss counter.
// - color tag bits 0,1 stream flags, bits 2-15 filter rule.
// - hashed HDLC code 19, hash in bits 0-3, color above; the code puts filter rule bits 0-11 above, without the stream flags.
// - hashed Ethernet code 20, Ethernet layout with hash tag.
// - type 20 payload equals length minus 16, extensions, minus two.
// - timestamp little-endian, other fields big-endian, payload in wire order.
// - length field gives total record bytes.
// - without extensions the type msb is zero.
module crf_formatter
	import crf_pkg::*;
(
	// clock and reset
	input  wire logic         CLK,
	input  wire logic         RSTN,
	// frame descriptor
	input  wire logic         IN_VALID,
	output logic              IN_READY,
	input  wire crf_desc_type IN_DESC,
	// extension header words, first byte in bits 63:56
	input  wire logic         EXT_VALID,
	output logic              EXT_READY,
	input  wire logic [63:0]  EXT_WORD,
	// payload bytes in wire order
	input  wire logic         PAY_VALID,
	output logic              PAY_READY,
	input  wire logic [7:0]   PAY_BYTE,
	// record byte stream
	output logic              OUT_VALID,
	input  wire logic         OUT_READY,
	output logic [7:0]        OUT_BYTE,
	output logic              OUT_LAST
);

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_GEN  = 5'b00010,
		ST_EXT  = 5'b00100,
		ST_PFX  = 5'b01000,
		ST_PAY  = 5'b10000
	} crf_state_type;

	typedef struct packed {
		crf_state_type state;
		crf_desc_type  desc;
		logic [127:0]  gen;
		logic [63:0]   ext;
		logic [31:0]   pfx;
		logic [15:0]   cnt;
		logic [2:0]    ext_left;
		logic          loaded;
		logic [7:0]    out_byte;
		logic          out_valid;
		logic          out_last;
	} crf_regs_type;

	crf_regs_type r;
	crf_regs_type next_r;

	logic [6:0]  code;
	logic        is_eth;
	logic [15:0] tag;
	logic [15:0] pfx_len;
	logic [15:0] rec_len;
	logic        slot_free;

	// ----------------------------------------
	// record header fields from the descriptor
	// ----------------------------------------
	always_comb begin
		is_eth = 1'b0;
		tag    = IN_DESC.loss_count;
		unique case (IN_DESC.variant)
			CRF_HDLC:       code = `CRF_TYPE_HDLC;
			CRF_ETH: begin
				code   = `CRF_ETHERNET_RECORD_TYPE;
				is_eth = 1'b1;
			end
			CRF_COLOR_HDLC: begin
				code = `CRF_TYPE_COLOR_HDLC;
				tag  = {IN_DESC.filter_rule, IN_DESC.stream_hit};
			end
			CRF_COLOR_ETH: begin
				code   = `CRF_COLORED_ETHERNET_RECORD_TYPE;
				is_eth = 1'b1;
				tag    = {IN_DESC.filter_rule, IN_DESC.stream_hit};
			end
			CRF_HASH_HDLC: begin
				code = `CRF_TYPE_HASH_HDLC;
				tag  = {IN_DESC.filter_rule[11:0], IN_DESC.hash};
			end
			CRF_HASH_ETH: begin
				code   = `CRF_HASHED_ETHERNET_RECORD_TYPE;
				is_eth = 1'b1;
				tag    = {IN_DESC.filter_rule[11:0], IN_DESC.hash};
			end
			// only the six listed codes; raw, pad and reserved never leave
			default: code = `CRF_TYPE_HDLC;
		endcase
		pfx_len = is_eth ? `CRF_ETH_PFX_BYTES : `CRF_HDLC_PFX_BYTES;
		// total length counts every byte emitted
		rec_len = `CRF_GEN_HDR_BYTES + pfx_len + IN_DESC.payload_len
			+ {10'h000, IN_DESC.ext_count, 3'h0};
	end

	// output slot is free when empty or being taken this cycle
	assign slot_free = !r.out_valid || OUT_READY;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		next_r    = r;
		IN_READY  = 1'b0;
		EXT_READY = 1'b0;
		PAY_READY = 1'b0;
		if (r.out_valid && OUT_READY) begin
			next_r.out_valid = 1'b0;
			next_r.out_last  = 1'b0;
		end
		unique case (r.state)
			ST_IDLE: begin
				IN_READY = 1'b1;
				if (IN_VALID) begin
					next_r.desc = IN_DESC;
					// timestamp bytes reversed so low byte leaves first
					next_r.gen = {IN_DESC.timestamp[7:0], IN_DESC.timestamp[15:8],
						IN_DESC.timestamp[23:16], IN_DESC.timestamp[31:24],
						IN_DESC.timestamp[39:32], IN_DESC.timestamp[47:40],
						IN_DESC.timestamp[55:48], IN_DESC.timestamp[63:56],
						(IN_DESC.ext_count != 3'h0), code,
						IN_DESC.flags, rec_len, tag, IN_DESC.wire_len};
					// offset byte left zero, pad byte zero
					next_r.pfx      = is_eth ? 32'h00000000 : IN_DESC.link_header;
					next_r.ext_left = IN_DESC.ext_count;
					next_r.cnt      = 16'h0000;
					next_r.state    = ST_GEN;
				end
			end
			ST_GEN: if (slot_free) begin
				next_r.out_byte  = r.gen[127:120];
				next_r.out_valid = 1'b1;
				next_r.gen       = {r.gen[119:0], 8'h00};
				next_r.cnt       = r.cnt + 16'h0001;
				if (r.cnt == `CRF_GEN_HDR_BYTES - 16'h0001) begin
					next_r.cnt    = 16'h0000;
					next_r.loaded = 1'b0;
					next_r.state  = (r.ext_left != 3'h0) ? ST_EXT : ST_PFX;
				end
			end
			ST_EXT: begin
				if (!r.loaded) begin
					EXT_READY = 1'b1;
					if (EXT_VALID) begin
						// chain bit forced by position, kind kept
						next_r.ext = {(r.ext_left != 3'h1), EXT_WORD[62:0]};
						next_r.loaded = 1'b1;
					end
				end else if (slot_free) begin
					next_r.out_byte  = r.ext[63:56];
					next_r.out_valid = 1'b1;
					next_r.ext       = {r.ext[55:0], 8'h00};
					next_r.cnt       = r.cnt + 16'h0001;
					if (r.cnt == `CRF_EXT_HDR_BYTES - 16'h0001) begin
						next_r.cnt      = 16'h0000;
						next_r.loaded   = 1'b0;
						next_r.ext_left = r.ext_left - 3'h1;
						if (r.ext_left == 3'h1)
							next_r.state = ST_PFX;
					end
				end
			end
			ST_PFX: if (slot_free) begin
				// prefix follows generic and extension headers
				next_r.out_byte  = r.pfx[31:24];
				next_r.out_valid = 1'b1;
				next_r.pfx       = {r.pfx[23:0], 8'h00};
				next_r.cnt       = r.cnt + 16'h0001;
				if (r.cnt == ((r.desc.variant == CRF_HDLC || r.desc.variant == CRF_COLOR_HDLC
					|| r.desc.variant == CRF_HASH_HDLC) ? `CRF_HDLC_PFX_BYTES
					: `CRF_ETH_PFX_BYTES) - 16'h0001) begin
					next_r.cnt = 16'h0000;
					if (r.desc.payload_len == 16'h0000) begin
						next_r.out_last = 1'b1;
						next_r.state    = ST_IDLE;
					end else
						next_r.state = ST_PAY;
				end
			end
			ST_PAY: if (slot_free) begin
				PAY_READY = 1'b1;
				if (PAY_VALID) begin
					next_r.out_byte  = PAY_BYTE;
					next_r.out_valid = 1'b1;
					next_r.cnt       = r.cnt + 16'h0001;
					if (r.cnt == r.desc.payload_len - 16'h0001) begin
						next_r.out_last = 1'b1;
						next_r.state    = ST_IDLE;
					end
				end
			end
			default: next_r.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			r       <= '0;
			r.state <= ST_IDLE;
		end else
			r <= next_r;
	end

	assign OUT_VALID = r.out_valid;
	assign OUT_BYTE  = r.out_byte;
	assign OUT_LAST  = r.out_last;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [15:0] byte_no;
	logic [15:0] len_field;
	logic        any_ext;
	logic [2:0]  ext_total;
	logic [2:0]  ext_loads;
	logic [3:0]  ext_seen;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			byte_no   <= 16'h0000;
			len_field <= 16'h0000;
			any_ext   <= 1'b0;
			ext_total <= 3'h0;
			ext_loads <= 3'h0;
			ext_seen  <= 4'h0;
		end else begin
			if (IN_VALID && IN_READY) begin
				any_ext   <= (IN_DESC.ext_count != 3'h0);
				ext_total <= IN_DESC.ext_count;
				ext_loads <= 3'h0;
				ext_seen  <= 4'h0;
			end
			if (EXT_VALID && EXT_READY) begin
				ext_loads <= ext_loads + 3'h1;
				ext_seen  <= 4'h0;
			end
			// counted apart from the sequencer so a miscount shows up
			if (r.state == ST_EXT && r.loaded && slot_free)
				ext_seen <= ext_seen + 4'h1;
			if (OUT_VALID && OUT_READY) begin
				byte_no <= OUT_LAST ? 16'h0000 : byte_no + 16'h0001;
				// length taken from the stream, since a next descriptor may land early
				if (byte_no == 16'h000a)
					len_field[15:8] <= OUT_BYTE;
				if (byte_no == 16'h000b)
					len_field[7:0] <= OUT_BYTE;
			end
		end
	end

	AST_LEN_AT_LAST: assert property (@(posedge CLK) disable iff (!RSTN)
		OUT_VALID && OUT_READY && OUT_LAST |-> byte_no == len_field - 16'h0001)
		else $error("record length differs from bytes emitted");
	AST_TYPE_MSB: assert property (@(posedge CLK) disable iff (!RSTN)
		OUT_VALID && byte_no == 16'h0008 |-> OUT_BYTE[7] == any_ext)
		else $error("type msb does not match extension presence");
	AST_NO_RSV: assert property (@(posedge CLK) disable iff (!RSTN)
		OUT_VALID && byte_no == 16'h0008 |-> !(OUT_BYTE[6:0] >= `CRF_TYPE_RSV_LO
		&& OUT_BYTE[6:0] <= `CRF_TYPE_RSV_HI))
		else $error("reserved type code emitted");
	AST_EXT_EIGHT: assert property (@(posedge CLK) disable iff (!RSTN)
		!(r.state == ST_EXT && r.loaded) |-> ext_seen == 4'h0 || ext_seen == 4'h8)
		else $error("extension header not eight bytes");
	AST_EXT_CHAIN: assert property (@(posedge CLK) disable iff (!RSTN)
		EXT_VALID && EXT_READY |=> r.ext[63] == (ext_loads != ext_total))
		else $error("extension chain bit wrong");
	AST_EXT_KIND: assert property (@(posedge CLK) disable iff (!RSTN)
		EXT_VALID && EXT_READY |=> r.ext[62:0] == $past(EXT_WORD[62:0]))
		else $error("extension kind or contents altered");
	AST_GEN_TO_NEXT: assert property (@(posedge CLK) disable iff (!RSTN)
		OUT_VALID && byte_no == 16'h0010 + {10'h000, ext_total, 3'h0}
		&& !(r.desc.variant inside {CRF_ETH, CRF_COLOR_ETH, CRF_HASH_ETH})
		|-> OUT_BYTE == r.desc.link_header[31:24])
		else $error("link header not right after the headers");
	AST_ETH_PAD: assert property (@(posedge CLK) disable iff (!RSTN)
		PAY_VALID && PAY_READY && r.cnt == 16'h0000
		&& r.desc.variant inside {CRF_ETH, CRF_COLOR_ETH, CRF_HASH_ETH}
		|=> OUT_VALID && byte_no == 16'h0012 + {10'h000, ext_total, 3'h0})
		else $error("ethernet frame not right after the pad byte");
	AST_PAY_ORDER: assert property (@(posedge CLK) disable iff (!RSTN)
		PAY_VALID && PAY_READY |=> OUT_VALID && OUT_BYTE == $past(PAY_BYTE))
		else $error("payload byte altered");

	COV_HDLC: cover property (@(posedge CLK) disable iff (!RSTN)
		IN_VALID && IN_READY && IN_DESC.variant == CRF_HDLC);
	COV_HASH_ETH: cover property (@(posedge CLK) disable iff (!RSTN)
		IN_VALID && IN_READY && IN_DESC.variant == CRF_HASH_ETH);
	COV_TWO_EXT: cover property (@(posedge CLK) disable iff (!RSTN)
		IN_VALID && IN_READY && IN_DESC.ext_count == 3'h2);
	COV_STALL: cover property (@(posedge CLK) disable iff (!RSTN)
		OUT_VALID && !OUT_READY ##1 OUT_VALID && OUT_READY && OUT_LAST);

endmodule

// ---- crf_host_sink.sv ----
/*
 host side of the record byte stream: takes record bytes and keeps them.
 assumes the bench clears got before each record and drives stall.
*/
`timescale 1ns/1ps
module crf_host_sink (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RSTN,
	// record stream
	input  wire logic       OUT_VALID,
	input  wire logic [7:0] OUT_BYTE,
	input  wire logic       OUT_LAST,
	output logic            OUT_READY,
	// stall pattern on
	input  wire logic       stall
);
	logic [7:0] got[$];
	int         recs = 0;
	int         last_pos = 0;
	logic [1:0] ph = 2'h0;

	initial OUT_READY = 1'b0;

	// a slow host takes one byte in three, like a busy memory path
	always @(posedge CLK) begin
		if (RSTN && OUT_VALID && OUT_READY) begin
			got.push_back(OUT_BYTE);
			if (OUT_LAST) begin
				last_pos = got.size();
				recs++;
			end
		end
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		#10 OUT_READY = RSTN && (!stall || ph == 2'h0);
	end
endmodule

// ---- crf_formatter_bench.sv ----
/*
 self-checking bench of the record formatter, all six variants.
 assumes crf_host_sink stands in for the host memory path.
*/
`timescale 1ns/1ps
module crf_formatter_bench
	import crf_pkg::*;
;
	logic         CLK = 1'b0;
	logic         RSTN = 1'b0;
	logic         IN_VALID = 1'b0;
	logic         EXT_VALID = 1'b0;
	logic         PAY_VALID = 1'b0;
	logic         stall = 1'b0;
	crf_desc_type IN_DESC = '0;
	logic [63:0]  EXT_WORD = '0;
	logic [7:0]   PAY_BYTE = '0;
	wire          IN_READY, EXT_READY, PAY_READY, OUT_VALID, OUT_READY, OUT_LAST;
	wire [7:0]    OUT_BYTE;
	int           err_count = 0;
	int           total_checks = 0;
	int           cyc = 0;

	crf_formatter i_crf_formatter (.CLK(CLK), .RSTN(RSTN), .IN_VALID(IN_VALID),
		.IN_READY(IN_READY), .IN_DESC(IN_DESC), .EXT_VALID(EXT_VALID),
		.EXT_READY(EXT_READY), .EXT_WORD(EXT_WORD), .PAY_VALID(PAY_VALID),
		.PAY_READY(PAY_READY), .PAY_BYTE(PAY_BYTE), .OUT_VALID(OUT_VALID),
		.OUT_READY(OUT_READY), .OUT_BYTE(OUT_BYTE), .OUT_LAST(OUT_LAST));
	crf_host_sink i_crf_host_sink (.CLK(CLK), .RSTN(RSTN), .OUT_VALID(OUT_VALID),
		.OUT_BYTE(OUT_BYTE), .OUT_LAST(OUT_LAST), .OUT_READY(OUT_READY), .stall(stall));

	always #50 CLK = ~CLK;

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			close_out();
		end
	end

	task automatic check(string nm, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ----------------------------------------
	// one record: drive, rebuild, compare
	// ----------------------------------------
	task automatic run(crf_variant_type v, int n, int len);
		crf_desc_type d;
		logic [63:0]  w[8];
		logic [7:0]   e[$];
		logic [15:0]  tag, rl;
		logic [6:0]   code;
		logic         more;
		int           k, j, r0, pfx;
		pfx = v[0] ? 2 : 4;
		case (v)
			CRF_HDLC:       code = `CRF_TYPE_HDLC;
			CRF_ETH:        code = `CRF_ETHERNET_RECORD_TYPE;
			CRF_COLOR_HDLC: code = `CRF_TYPE_COLOR_HDLC;
			CRF_COLOR_ETH:  code = `CRF_COLORED_ETHERNET_RECORD_TYPE;
			CRF_HASH_HDLC:  code = `CRF_TYPE_HASH_HDLC;
			default:        code = `CRF_HASHED_ETHERNET_RECORD_TYPE;
		endcase
		tag = 16'hbeef;
		if (v == CRF_COLOR_HDLC || v == CRF_COLOR_ETH)
			tag = {14'h3a5c, 2'h2};
		if (v == CRF_HASH_HDLC || v == CRF_HASH_ETH)
			tag = {12'ha5c, 4'h9};
		d = '0;
		d.variant = v;
		d.timestamp = 64'h0807060504030201 + 64'(v);
		d.flags = 8'h04;
		d.wire_len = 16'(len + 4);
		d.loss_count = 16'hbeef;
		d.stream_hit = 2'h2;
		d.filter_rule = 14'h3a5c;
		d.hash = 4'h9;
		d.link_header = 32'hff030021;
		d.ext_count = 3'(n);
		d.payload_len = 16'(len);
		rl = 16'(16 + 8 * n + pfx + len);
		for (k = 0; k < 8; k++)
			e.push_back(d.timestamp[8*k +: 8]);
		e.push_back({n != 0, code});
		e.push_back(8'h04);
		for (k = 1; k >= 0; k--)
			e.push_back(rl[8*k +: 8]);
		for (k = 1; k >= 0; k--)
			e.push_back(tag[8*k +: 8]);
		for (k = 1; k >= 0; k--)
			e.push_back(d.wire_len[8*k +: 8]);
		for (k = 0; k < n; k++) begin
			more = (k < n - 1);
			// chain bit offered inverted so the device has to set it itself
			w[k] = {~more, 7'(8'h10 + k), 56'h11223344556677};
			e.push_back({more, w[k][62:56]});
			for (j = 6; j >= 0; j--)
				e.push_back(w[k][8*j +: 8]);
		end
		if (pfx == 4) begin
			for (j = 3; j >= 0; j--)
				e.push_back(d.link_header[8*j +: 8]);
		end else begin
			e.push_back(8'h00);
			e.push_back(8'h00);
		end
		for (k = 0; k < len; k++)
			e.push_back(8'(8'ha0 + k));
		i_crf_host_sink.got.delete();
		r0 = i_crf_host_sink.recs;
		IN_DESC = d;
		IN_VALID = 1'b1;
		do @(negedge CLK); while (IN_READY !== 1'b1);
		@(posedge CLK);
		#10 IN_VALID = 1'b0;
		for (k = 0; k < n; k++) begin
			EXT_WORD = w[k];
			EXT_VALID = 1'b1;
			do @(negedge CLK); while (EXT_READY !== 1'b1);
			@(posedge CLK);
			#10;
		end
		EXT_VALID = 1'b0;
		for (k = 0; k < len; k++) begin
			PAY_BYTE = 8'(8'ha0 + k);
			PAY_VALID = 1'b1;
			do @(negedge CLK); while (PAY_READY !== 1'b1);
			@(posedge CLK);
			#10;
		end
		PAY_VALID = 1'b0;
		for (k = 0; k < 2000 && i_crf_host_sink.recs == r0; k++)
			@(posedge CLK);
		#10;
		check("record seen", 16'h0001, 16'(i_crf_host_sink.recs - r0));
		check("record end", 16'(e.size()), 16'(i_crf_host_sink.last_pos));
		for (k = 0; k < e.size(); k++)
			// offset byte contents are disregarded by the host
			if (pfx == 4 || k != 16 + 8 * n)
				check("record byte", 16'(e[k]), 16'(i_crf_host_sink.got[k]));
		check("reserved type", 16'h0, 16'(i_crf_host_sink.got[8][6:0] inside {[32:47], 24, 48}));
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_hdlc;
		stall = 1'b0;
		run(CRF_HDLC, 0, 3);
		run(CRF_HASH_HDLC, 7, 2);
		$display("test hdlc done");
	endtask

	task automatic test_eth;
		stall = 1'b1;
		run(CRF_ETH, 2, 5);
		run(CRF_HASH_ETH, 1, 1);
		$display("test eth done");
	endtask

	task automatic test_color;
		stall = 1'b0;
		run(CRF_COLOR_HDLC, 1, 2);
		stall = 1'b1;
		run(CRF_COLOR_ETH, 0, 4);
		$display("test color done");
	endtask

	initial begin
		repeat (4) @(posedge CLK);
		#10 RSTN = 1'b1;
		test_hdlc();
		test_eth();
		test_color();
		close_out();
	end
endmodule
